// ---- core/tmr3_presc.sv ----
`timescale 1ns/10ps
module tmr3_presc
  import tmr3_pkg::*;
(
  input  wire logic   i_core_clk,
  input  wire logic   i_rstn,
  tmr3_presc_if.presc bus
);
  typedef struct packed {
    logic [PRESC_W-1:0] cnt;
    logic               active_edge;
  } tmr3_presc_type;

  tmr3_presc_type     q;
  tmr3_presc_type     d;
  logic [PRESC_W-1:0] mask;

  // mask follows the divider at once, no wait for a boundary
  always_comb begin
    mask = PRESC_W'((8'h01 << bus.div) - 8'h01);
    d = q;
    d.active_edge = bus.tick && ((q.cnt & mask) == mask);
    if (bus.tick) begin
      d.cnt = q.cnt + PRESC_W'(1);
    end
    if (!i_rstn) begin
      d = '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    q <= d;
  end

  assign bus.active_edge = q.active_edge;

  div_max_rate_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (bus.active_edge && $past(bus.div) == 3'h7) |-> $past(q.cnt) == 7'h7f)
    else $error("divide by 128 edge off phase");
  div_one_rate_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (bus.tick && bus.div == 3'h0) |=> bus.active_edge)
    else $error("divide by 1 missed a tick");
endmodule

// ---- core/tmr3_top.sv ----
`timescale 1ns/10ps
// Function
// - active counter edge is tick divided by two to the divider field power
// - divider changes take effect immediately on the edge rate
// - writing one to the clear bit forces the counter to zero
// - clear bit is write-one only and always reads zero
// - mode 00 counts zero to 0xff and wraps forever
// - mode 01 counts down once from compare value to zero
// - mode 10 counts up to compare value then restarts at zero
// - mode 11 counts up to compare value then back down, repeating
// - channel interrupt mask at bit 6, resets to one, enables compare irq
// - on match action codes set, clear or toggle the channel output
// - codes 011/100 act on upward compare and zero, or downward compare
// - code 101 sets on compare and clears at 0xff
// - code 110 clears on compare and sets at zero; 111 unused
// - output actions only while compare enable bit is one; resets zero
// - eight bit compare value, resets zero, also sets period or reload
// - start bit one runs the counter, zero holds its value
// - overflow irq only when overflow mask and global enable are one
// - counter value readable in a read only register, resets zero
// - compare mode drives the pin and applies actions glitch free
module tmr3_top
  import tmr3_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_timer_tick,
  input  wire logic [AXI_AW-1:0] i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output wire logic              o_s_axi_awready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output wire logic              o_s_axi_wready,
  output wire logic [1:0]        o_s_axi_bresp,
  output wire logic              o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  input  wire logic [AXI_AW-1:0] i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output wire logic              o_s_axi_arready,
  output wire logic [31:0]       o_s_axi_rdata,
  output wire logic [1:0]        o_s_axi_rresp,
  output wire logic              o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  output wire logic              o_ch0_out,
  output wire logic              o_ch0_oe,
  output wire logic              o_ovf_irq,
  output wire logic              o_ch0_irq
);
  typedef struct packed {
    logic [2:0]        div;
    logic              start;
    logic              ovf_mask;
    tmr3_mode_type     mode;
    logic              ch_mask;
    tmr3_act_type      action;
    logic              cmp_en;
    logic [1:0]        rsv;
    logic [7:0]        cc0;
    logic              glob_en;
    logic [7:0]        cnt;
    logic              dir_down;
    logic              pin;
    logic              oe;
    logic              ovf_irq;
    logic              ch_irq;
    logic              awready;
    logic              wready;
    logic              aw_have;
    logic              w_have;
    logic [AXI_AW-1:0] awaddr;
    logic [7:0]        wdata;
    logic              wlane;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
  } tmr3_state_type;

  tmr3_state_type q;
  tmr3_state_type d;
  logic           run;
  logic           match;
  logic           zero;
  logic           cmp_up;
  logic           ovf_evt;
  logic           ch_evt;
  logic           do_wr;
  logic           wr_ctl;
  logic           rd_ctl;
  logic           arr_match;
  logic           arr_zero;
  logic           arr_back;

  tmr3_presc_if pif ();

  assign pif.tick = i_timer_tick;
  assign pif.div  = q.div;

  tmr3_presc u_presc (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .bus        (pif)
  );

  function automatic logic hit(input logic [AXI_AW-1:0] addr, input logic [7:0] idx);
    hit = (addr[AXI_AW-1:2] == {2'h0, idx});
  endfunction

  always_comb begin
    d       = q;
    run     = pif.active_edge && q.start;
    match   = (q.cnt == q.cc0);
    zero    = (q.cnt == CNT_ZERO);
    cmp_up  = !q.dir_down && (q.mode != TMR3_DOWN);
    ovf_evt = 1'b0;
    ch_evt  = 1'b0;
    do_wr   = 1'b0;
    wr_ctl  = 1'b0;
    rd_ctl  = 1'b0;
    arr_match = 1'b0;
    arr_zero  = 1'b0;
    arr_back  = 1'b0;
    if (run) begin
      case (q.mode)
        TMR3_FREE: begin
          ovf_evt = (q.cnt == CNT_TOP);
          d.cnt   = q.cnt + 8'h01;
        end
        TMR3_DOWN: begin
          // single pass: parks at zero until restarted
          if (!zero) begin
            d.cnt   = q.cnt - 8'h01;
            ovf_evt = (q.cnt == 8'h01);
          end
        end
        TMR3_MODULO: begin
          if (match) begin
            d.cnt   = CNT_ZERO;
            ovf_evt = 1'b1;
          end else begin
            d.cnt = q.cnt + 8'h01;
          end
        end
        TMR3_UPDOWN: begin
          if (!q.dir_down) begin
            if (match) begin
              d.dir_down = !zero;
              d.cnt      = zero ? CNT_ZERO : q.cnt - 8'h01;
            end else begin
              d.cnt = q.cnt + 8'h01;
            end
          end else if (zero) begin
            d.dir_down = 1'b0;
            d.cnt      = match ? CNT_ZERO : q.cnt + 8'h01;
          end else begin
            d.cnt   = q.cnt - 8'h01;
            ovf_evt = (q.cnt == 8'h01);
          end
        end
        default: begin
          d.cnt = q.cnt;
        end
      endcase
      // actions key on the value just reached, so the pin moves as the counter lands
      arr_match = (d.cnt == q.cc0);
      arr_zero  = (d.cnt == CNT_ZERO);
      arr_back  = (q.mode == TMR3_UPDOWN) ? (arr_match && q.dir_down) : arr_zero;
      // in up/down the channel event moves to the zero turnaround
      ch_evt = (q.mode == TMR3_UPDOWN) ? (q.dir_down && arr_zero) : arr_match;
      // pin only changes at a registered edge, so it cannot glitch
      if (q.cmp_en) begin
        case (q.action)
          TMR3_ACT_SET: begin
            if (arr_match) d.pin = 1'b1;
          end
          TMR3_ACT_CLEAR: begin
            if (arr_match) d.pin = 1'b0;
          end
          TMR3_ACT_TGL: begin
            if (arr_match) d.pin = !q.pin;
          end
          TMR3_ACT_UPSET: begin
            if (arr_match && cmp_up) d.pin = 1'b1;
            else if (arr_back) d.pin = 1'b0;
          end
          TMR3_ACT_UPCLR: begin
            if (arr_match && cmp_up) d.pin = 1'b0;
            else if (arr_back) d.pin = 1'b1;
          end
          TMR3_ACT_SET_TOP: begin
            if (arr_match) d.pin = 1'b1;
            else if (d.cnt == CNT_TOP) d.pin = 1'b0;
          end
          TMR3_ACT_CLEAR_ZERO: begin
            if (arr_match) d.pin = 1'b0;
            else if (arr_zero) d.pin = 1'b1;
          end
          default: begin
            d.pin = q.pin;
          end
        endcase
      end
    end
    d.ovf_irq = ovf_evt && q.ovf_mask && q.glob_en;
    d.ch_irq  = ch_evt && q.ch_mask && q.glob_en;
    d.oe      = q.cmp_en;

    // write side: address and data are taken in either order
    if (i_s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awaddr  = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata  = i_s_axi_wdata[7:0];
      d.wlane  = i_s_axi_wstrb[0];
    end
    if (q.bvalid && i_s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    do_wr  = d.aw_have && d.w_have && !q.bvalid;
    wr_ctl = do_wr && d.wlane && hit(d.awaddr, IDX_CTL);
    if (do_wr) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      if (d.wlane) begin
        if (hit(d.awaddr, IDX_CTL)) begin
          d.div      = d.wdata[CTL_DIV_LSB +: 3];
          d.start    = d.wdata[CTL_START];
          d.ovf_mask = d.wdata[CTL_OVF_MASK];
          d.mode     = tmr3_mode_type'(d.wdata[CTL_MODE_LSB +: 2]);
          // a fresh start in down mode reloads from the compare value
          if (d.wdata[CTL_START] && !q.start && d.mode == TMR3_DOWN) begin
            d.cnt      = q.cc0;
            d.dir_down = 1'b1;
          end
          if (d.wdata[CTL_CLEAR]) begin
            d.cnt      = CNT_ZERO;
            d.dir_down = (d.mode == TMR3_DOWN);
          end
        end else if (hit(d.awaddr, IDX_CCTL)) begin
          d.ch_mask = d.wdata[CCTL_MASK];
          d.action  = tmr3_act_type'(d.wdata[CCTL_ACT_LSB +: 3]);
          d.cmp_en  = d.wdata[CCTL_EN];
          d.rsv     = d.wdata[CCTL_RSV_LSB +: 2];
        end else if (hit(d.awaddr, IDX_CC0)) begin
          d.cc0 = d.wdata;
        end else if (hit(d.awaddr, IDX_GIE)) begin
          d.glob_en = d.wdata[GIE_EN];
        end
      end
      if (!(hit(d.awaddr, IDX_CTL) || hit(d.awaddr, IDX_CCTL) || hit(d.awaddr, IDX_CC0)
            || hit(d.awaddr, IDX_GIE) || hit(d.awaddr, IDX_CNT))) begin
        d.bresp = RESP_SLVERR;
      end
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;

    // read side: one read at a time, data held until rready
    if (q.rvalid && i_s_axi_rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end
    if (i_s_axi_arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = RESP_OKAY;
      rd_ctl    = hit(i_s_axi_araddr, IDX_CTL);
      if (hit(i_s_axi_araddr, IDX_CNT)) begin
        d.rdata = q.cnt;
      end else if (rd_ctl) begin
        // clear bit is write-one only and always reads back zero
        d.rdata = {q.div, q.start, q.ovf_mask, 1'b0, q.mode};
      end else if (hit(i_s_axi_araddr, IDX_CCTL)) begin
        d.rdata = {1'b0, q.ch_mask, q.action, q.cmp_en, q.rsv};
      end else if (hit(i_s_axi_araddr, IDX_CC0)) begin
        d.rdata = q.cc0;
      end else if (hit(i_s_axi_araddr, IDX_GIE)) begin
        d.rdata = {7'h00, q.glob_en};
      end else begin
        d.rdata = 8'h00;
        d.rresp = RESP_SLVERR;
      end
    end

    if (!i_rstn) begin
      d          = '0;
      d.div      = DIV_RST;
      d.ovf_mask = OVF_MASK_RST;
      d.ch_mask  = CH_MASK_RST;
      d.cc0      = CC0_RST;
      d.cnt      = CNT_RST;
      d.mode     = TMR3_FREE;
      d.action   = TMR3_ACT_SET;
      d.awready  = 1'b1;
      d.wready   = 1'b1;
      d.arready  = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    q <= d;
  end

  assign o_s_axi_awready = q.awready;
  assign o_s_axi_wready  = q.wready;
  assign o_s_axi_bresp   = q.bresp;
  assign o_s_axi_bvalid  = q.bvalid;
  assign o_s_axi_arready = q.arready;
  assign o_s_axi_rdata   = {24'h000000, q.rdata};
  assign o_s_axi_rresp   = q.rresp;
  assign o_s_axi_rvalid  = q.rvalid;
  assign o_ch0_out       = q.pin;
  assign o_ch0_oe        = q.oe;
  assign o_ovf_irq       = q.ovf_irq;
  assign o_ch0_irq       = q.ch_irq;

  clear_reads_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_s_axi_arvalid && q.arready && rd_ctl) |=> (q.rvalid && q.rdata[CTL_CLEAR] == 1'b0))
    else $error("clear bit read back as one");
  clear_forces_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (wr_ctl && d.wdata[CTL_CLEAR]) |=> (q.cnt == CNT_ZERO))
    else $error("clear write left counter nonzero");
  free_wraps_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (run && q.mode == TMR3_FREE && q.cnt == CNT_TOP && !wr_ctl) |=> (q.cnt == CNT_ZERO))
    else $error("free running counter did not wrap");
  down_parks_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (q.mode == TMR3_DOWN && q.cnt == CNT_ZERO && !wr_ctl) |=> (q.cnt == CNT_ZERO))
    else $error("down mode left zero");
  modulo_restart_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (run && q.mode == TMR3_MODULO && match && !wr_ctl)
      |=> (q.cnt == CNT_ZERO && o_ovf_irq == $past(q.ovf_mask && q.glob_en)))
    else $error("modulo did not restart");
  updown_turn_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (run && q.mode == TMR3_UPDOWN && !q.dir_down && match && !zero && !wr_ctl)
      |=> (q.dir_down && q.cnt == $past(q.cc0) - 8'h01))
    else $error("up/down did not turn at compare value");
  halt_holds_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (!q.start && !wr_ctl) |=> $stable(q.cnt))
    else $error("halted counter moved");
  ovf_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_ovf_irq |-> $past(q.ovf_mask && q.glob_en))
    else $error("overflow irq without both enables");
  pin_disabled_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !q.cmp_en |=> (o_ch0_out == $past(o_ch0_out)))
    else $error("pin changed with compare disabled");
  pin_set_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (run && q.cmp_en && q.action == TMR3_ACT_SET && arr_match) |=> o_ch0_out)
    else $error("set action did not set pin");
endmodule

// ---- shared/tmr3_pkg.sv ----
package tmr3_pkg;
  localparam int AXI_AW = 12;
  localparam int PRESC_W = 7;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_GIE  = 8'hc0;
  localparam logic [7:0] IDX_CNT  = 8'hca;
  localparam logic [7:0] IDX_CTL  = 8'hcb;
  localparam logic [7:0] IDX_CCTL = 8'hcc;
  localparam logic [7:0] IDX_CC0  = 8'hcd;
  // control register fields
  localparam int CTL_DIV_LSB = 5;
  localparam int CTL_START   = 4;
  localparam int CTL_OVF_MASK = 3;
  localparam int CTL_CLEAR   = 2;
  localparam int CTL_MODE_LSB = 0;
  // channel control fields and global enable bit
  localparam int CCTL_MASK    = 6;
  localparam int CCTL_ACT_LSB = 3;
  localparam int CCTL_EN      = 2;
  localparam int CCTL_RSV_LSB = 0;
  localparam int GIE_EN       = 0;
  // reset values, counter limits and bus response codes
  localparam logic [2:0] DIV_RST   = 3'h0;
  localparam logic       OVF_MASK_RST = 1'b1;
  localparam logic       CH_MASK_RST  = 1'b1;
  localparam logic [7:0] CC0_RST   = 8'h00;
  localparam logic [7:0] CNT_RST   = 8'h00;
  localparam logic [7:0] CNT_TOP   = 8'hff;
  localparam logic [7:0] CNT_ZERO  = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TMR3_FREE   = 2'h0,
    TMR3_DOWN   = 2'h1,
    TMR3_MODULO = 2'h2,
    TMR3_UPDOWN = 2'h3
  } tmr3_mode_type;
  typedef enum logic [2:0] {
    TMR3_ACT_SET     = 3'h0,
    TMR3_ACT_CLEAR   = 3'h1,
    TMR3_ACT_TGL     = 3'h2,
    TMR3_ACT_UPSET   = 3'h3,
    TMR3_ACT_UPCLR   = 3'h4,
    TMR3_ACT_SET_TOP = 3'h5,
    TMR3_ACT_CLEAR_ZERO = 3'h6,
    TMR3_ACT_NONE    = 3'h7
  } tmr3_act_type;
endpackage

// ---- shared/tmr3_presc_if.sv ----
`timescale 1ns/10ps
interface tmr3_presc_if;
  logic       tick;
  logic [2:0] div;
  logic       active_edge;
  modport core  (output tick, output div, input active_edge);
  modport presc (input tick, input div, output active_edge);
endinterface

// ---- verif/tmr3_top_tb.sv ----
`timescale 1ns/10ps
module tmr3_top_tb;
  import tmr3_pkg::*;
  logic              clk;
  logic              rstn;
  logic              tick;
  logic [AXI_AW-1:0] awaddr;
  logic [AXI_AW-1:0] araddr;
  logic              awvalid;
  logic              wvalid;
  logic              bready;
  logic              arvalid;
  logic              rready;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  wire logic         awready;
  wire logic         wready;
  wire logic         bvalid;
  wire logic         arready;
  wire logic         rvalid;
  wire logic [1:0]   bresp;
  wire logic [1:0]   rresp;
  wire logic [31:0]  rdata;
  wire logic         ch_out;
  wire logic         ch_oe;
  wire logic         ovf_irq;
  wire logic         ch_irq;
  int                err_total = 0;
  int                checked = 0;
  int                ovf_n = 0;
  int                ch_n = 0;
  int                i;
  int                k;
  // channel table: control byte, ticks to apply, expected output level
  logic [7:0]        tb_cc [16] = '{8'h40, 8'h44, 8'h44, 8'h4c, 8'h4c, 8'h54, 8'h54, 8'h54,
                                    8'h5c, 8'h5c, 8'h64, 8'h64, 8'h6c, 8'h6c, 8'h74, 8'h74};
  int                tb_n [16] = '{6, 5, 1, 5, 1, 5, 6, 1, 5, 1, 5, 1, 5, 250, 1, 5};
  logic [15:0]       tb_ex = 16'h5926;

  tmr3_top uut (
    .i_core_clk      (clk),
    .i_rstn          (rstn),
    .i_timer_tick    (tick),
    .i_s_axi_awaddr  (awaddr),
    .i_s_axi_awvalid (awvalid),
    .o_s_axi_awready (awready),
    .i_s_axi_wdata   (wdata),
    .i_s_axi_wstrb   (wstrb),
    .i_s_axi_wvalid  (wvalid),
    .o_s_axi_wready  (wready),
    .o_s_axi_bresp   (bresp),
    .o_s_axi_bvalid  (bvalid),
    .i_s_axi_bready  (bready),
    .i_s_axi_araddr  (araddr),
    .i_s_axi_arvalid (arvalid),
    .o_s_axi_arready (arready),
    .o_s_axi_rdata   (rdata),
    .o_s_axi_rresp   (rresp),
    .o_s_axi_rvalid  (rvalid),
    .i_s_axi_rready  (rready),
    .o_ch0_out       (ch_out),
    .o_ch0_oe        (ch_oe),
    .o_ovf_irq       (ovf_irq),
    .o_ch0_irq       (ch_irq)
  );

  always #5 clk = ~clk;

  // irq outputs are single-cycle pulses, so count them at every edge
  always @(posedge clk) begin
    if (ovf_irq === 1'h1) ovf_n++;
    if (ch_irq === 1'h1) ch_n++;
  end

  task automatic final_report();
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic timeout_hit();
    err_total++;
    final_report();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h got %h", nm, e, g);
      err_total++;
    end
  endtask

  function automatic logic [7:0] cv(input int dv, st, ov, cl, md);
    return 8'((dv << 5) | (st << 4) | (ov << 3) | (cl << 2) | md);
  endfunction

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s = 4'h1,
                    input logic [1:0] er = RESP_OKAY);
    int   n;
    logic ad;
    logic wd;
    n = 0;
    ad = 1'h0;
    wd = 1'h0;
    awaddr  <= AXI_AW'({idx, 2'h0});
    wdata   <= {24'h0, d};
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge clk);
      n++;
      if (!ad && awready === 1'h1) begin
        ad = 1'h1;
        awvalid <= 1'h0;
      end
      if (!wd && wready === 1'h1) begin
        wd = 1'h1;
        wvalid <= 1'h0;
      end
      if (n > 50) timeout_hit();
    end
    do begin
      @(posedge clk);
      n++;
      if (n > 50) timeout_hit();
    end while (bvalid !== 1'h1);
    chk("bresp", 32'(er), 32'(bresp));
    bready <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rdr(input logic [7:0] idx, input string nm, input logic [7:0] e,
                     input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    araddr  <= AXI_AW'({idx, 2'h0});
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) timeout_hit();
    end while (arready !== 1'h1);
    arvalid <= 1'h0;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) timeout_hit();
    end while (rvalid !== 1'h1);
    chk(nm, {24'h0, e}, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    rready <= 1'h0;
    @(posedge clk);
  endtask

  // ticks land one per clock; the settle cycles cover the registered edge and update
  task automatic tk(input int n);
    repeat (n) begin
      tick <= 1'h1;
      @(posedge clk);
    end
    tick <= 1'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic go(input int md);
    wr(IDX_CTL, cv(0, 0, 1, 1, md));
    wr(IDX_CTL, cv(0, 1, 1, 0, md));
  endtask

  initial begin
    #900000;
    timeout_hit();
  end

  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    tick = 1'h0;
    awaddr = '0;
    araddr = '0;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    rdr(IDX_CTL, "ctl", 8'h08);
    rdr(IDX_CCTL, "cctl", 8'h40);
    rdr(IDX_CC0, "cc0", CC0_RST);
    rdr(IDX_CNT, "cnt", CNT_RST);
    rdr(8'hd0, "unmapped", 8'h00, RESP_SLVERR);
    wr(8'hd0, 8'h11, 4'h1, RESP_SLVERR);
    wr(IDX_CCTL, 8'hfc);
    rdr(IDX_CCTL, "cctl", 8'h7c);
    wr(IDX_CCTL, 8'h40);
    wr(IDX_CC0, 8'ha5);
    wr(IDX_CC0, 8'h3c, 4'h0);
    rdr(IDX_CC0, "cc0", 8'ha5);
    wr(IDX_CNT, 8'h77);
    rdr(IDX_CNT, "cnt", 8'h00);
    wr(IDX_CTL, cv(0, 0, 1, 1, 0));
    rdr(IDX_CTL, "ctl", 8'h08);
    // whole prescaler periods give an exact edge count whatever the phase
    for (i = 0; i < 8; i++) begin
      wr(IDX_CTL, cv(i, 0, 1, 1, 0));
      wr(IDX_CTL, cv(i, 1, 1, 0, 0));
      tk(3 << i);
      wr(IDX_CTL, cv(i, 0, 1, 0, 0));
      tk(1 << i);
      rdr(IDX_CNT, "cnt_div", 8'h03);
    end
    for (i = 0; i < 3; i++) begin
      wr(IDX_GIE, 8'(i != 2));
      wr(IDX_CTL, cv(0, 0, i != 1, 1, 0));
      wr(IDX_CTL, cv(0, 1, i != 1, 0, 0));
      k = ovf_n;
      tk(257);
      rdr(IDX_CNT, "cnt_wrap", 8'h01);
      chk("ovf_irq", 32'(i == 0), ovf_n - k);
    end
    wr(IDX_GIE, 8'h01);
    wr(IDX_CC0, 8'h05);
    go(2);
    tk(14);
    rdr(IDX_CNT, "cnt_mod", 8'h02);
    wr(IDX_CC0, 8'h03);
    go(3);
    tk(5);
    rdr(IDX_CNT, "cnt_updown", 8'h01);
    wr(IDX_CC0, 8'h05);
    go(1);
    tk(3);
    rdr(IDX_CNT, "cnt_down", 8'h02);
    tk(10);
    rdr(IDX_CNT, "cnt_down", 8'h00);
    go(2);
    k = ch_n;
    for (i = 0; i < 16; i++) begin
      wr(IDX_CTL, cv(0, 1, 1, 0, (i < 12) ? 2 : 0));
      wr(IDX_CCTL, tb_cc[i]);
      tk(tb_n[i]);
      chk("ch_out", 32'(tb_ex[i]), 32'(ch_out));
      chk("ch_oe", 32'(tb_cc[i][2]), 32'(ch_oe));
    end
    chk("ch_irq", 32'h1, 32'(ch_n > k));
    wr(IDX_CTL, cv(0, 1, 1, 0, 2));
    wr(IDX_CCTL, 8'h04);
    k = ch_n;
    tk(12);
    chk("ch_irq", 32'h0, ch_n - k);
    final_report();
  end
endmodule
